// ==== pkg/sgpc_pkg.sv ====
// types of the servo gain and profile command interpreter
package sgpc_pkg;

  typedef enum logic [9:0] {
    SGPC_IDLE = 10'h001,
    SGPC_CMD1 = 10'h002,
    SGPC_CMD2 = 10'h004,
    SGPC_BODY = 10'h008,
    SGPC_EXEC = 10'h010,
    SGPC_READ = 10'h020,
    SGPC_HASH = 10'h040,
    SGPC_SIGN = 10'h080,
    SGPC_DIG  = 10'h100,
    SGPC_TERM = 10'h200
  } sgpc_state_t;

  // values held by the servo loop for one motor, read back by get commands
  typedef struct packed {
    logic        [15:0] ff_accel;
    logic        [15:0] ff_decel;
    logic        [15:0] amplitude;
    logic        [15:0] deriv_gain;
    logic        [15:0] integ_gain;
    logic        [7:0]  ff_friction;
    logic signed [15:0] cur_offset;
    logic signed [15:0] prof_offset;
    logic        [7:0]  err_word;
    logic        [8:0]  warn_word;
  } sgpc_motor_t;

  // one accepted set command, handed to the servo loop
  typedef struct packed {
    logic        kind;
    logic [1:0]  motor;
    logic [15:0] value;
  } sgpc_upd_t;

endpackage : sgpc_pkg

// ==== pkg/sgpc_regs.svh ====
// constants of the servo gain and profile command interpreter
// Overview of operation
// R1 - request is '!', two letters, value, motor, CR; reply is '#' ... CR
// R2 - set P gain stores unsigned 0..32640 per motor, acks; get returns it
// R3 - set profile speed stores 0..4096; 4096 is designed rate, linear
// R4 - profile speed change is accepted at any time, even mid profile
// R5 - get profile speed returns the stored 0..4096 value of that motor
// R6 - get FF acceleration returns stored 0..32640 value of that motor
// R7 - get FF deceleration returns stored 0..32640 value of that motor
// R8 - get profile amplitude returns 0..4096, 4096 meaning full amplitude
// R9 - get D gain returns stored 0..32640 value of that motor
// R10 - get motor error returns bits 0..7 status word, bit 4 reserved
// R11 - get FF friction returns stored 0..255 value of that motor
// R12 - get I gain returns stored 0..32640 value of that motor
// R13 - get current offset returns signed -256..256 value of that motor
// R14 - get profile offset returns signed -32256..32256 of that motor
// R15 - get motor warning returns bits 0..8 status word, reserved bits zero
// R16 - decimal value with optional sign; bad frames get a negative ack
// R17 - exactly one reply per request, in order, before the next request
`ifndef SGPC_REGS_SVH
`define SGPC_REGS_SVH

`define SGPC_CH_BANG   8'h21
`define SGPC_CH_HASH   8'h23
`define SGPC_CH_CR     8'h0d
`define SGPC_CH_PLUS   8'h2b
`define SGPC_CH_MINUS  8'h2d
`define SGPC_CH_ZERO   8'h30
`define SGPC_CH_NINE   8'h39
`define SGPC_MOT_FIRST 8'h41
`define SGPC_MOT_LAST  8'h44
`define SGPC_GRP_SET   8'h44
`define SGPC_GRP_GET   8'h45
`define SGPC_K_FFACC   8'h41
`define SGPC_K_FFDEC   8'h42
`define SGPC_K_AMPL    8'h43
`define SGPC_K_DGAIN   8'h44
`define SGPC_K_MERR    8'h45
`define SGPC_K_FRIC    8'h46
`define SGPC_K_IGAIN   8'h49
`define SGPC_K_COFF    8'h4b
`define SGPC_K_POFF    8'h4f
`define SGPC_K_PGAIN   8'h50
`define SGPC_K_SPEED   8'h53
`define SGPC_K_MWARN   8'h57

`define SGPC_GAIN_MAX  17'h07f80
`define SGPC_SPEED_MAX 17'h01000
`define SGPC_SPEED_RST 16'h1000
`define SGPC_GAIN_RST  16'h0000
`define SGPC_VAL_SAT   17'h1ffff
`define SGPC_ACK_OK    17'h00000
`define SGPC_ACK_BAD   17'h00001
`define SGPC_BODY_MAX  4'h8
`define SGPC_TEN       21'h0000a
`define SGPC_POW0      17'h00001
`define SGPC_POW1      17'h0000a
`define SGPC_POW2      17'h00064
`define SGPC_POW3      17'h003e8
`define SGPC_POW4      17'h02710
`define SGPC_PIDX_TOP  3'h4
`define SGPC_KIND_P    1'b0
`define SGPC_KIND_S    1'b1

`endif

// ==== rtl/sgpc_cmd_interp.sv ====
// ascii command interpreter for gain and motion profile commands
`timescale 1ns/10ps
`include "sgpc_regs.svh"
module sgpc_cmd_interp
  import sgpc_pkg::*;
(
  input  wire logic              i_mclk,
  input  wire logic              i_sys_rst,
  input  wire logic              i_rx_valid,
  input  wire logic [7:0]        i_rx_data,
  output logic                   o_rx_ready,
  output logic                   o_tx_valid,
  output logic      [7:0]        o_tx_data,
  input  wire logic              i_tx_ready,
  input  wire sgpc_motor_t [3:0] i_motor,
  output logic                   o_upd_valid,
  output sgpc_upd_t              o_upd
);

  function automatic logic [16:0] pow10(input logic [2:0] idx);
    unique case (idx)
      3'h0:    pow10 = `SGPC_POW0;
      3'h1:    pow10 = `SGPC_POW1;
      3'h2:    pow10 = `SGPC_POW2;
      3'h3:    pow10 = `SGPC_POW3;
      default: pow10 = `SGPC_POW4;
    endcase
  endfunction : pow10

  // signed value to sign flag and magnitude
  function automatic logic [17:0] sgn_mag(input logic signed [15:0] v);
    logic [16:0] ext;
    ext = {v[15], v};
    if (v[15]) begin
      sgn_mag = {1'b1, 17'(-ext)};
    end else begin
      sgn_mag = {1'b0, ext};
    end
  endfunction : sgn_mag

  function automatic logic [16:0] zext16(input logic [15:0] v);
    zext16 = {1'b0, v};
  endfunction : zext16

  sgpc_state_t st_q, st_d;
  logic [7:0]  c1_q, c1_d, c2_q, c2_d;
  logic        neg_q, neg_d;
  logic [16:0] val_q, val_d;
  logic        hasdig_q, hasdig_d;
  logic [3:0]  bodyn_q, bodyn_d;
  logic [1:0]  mot_q, mot_d;
  logic        motok_q, motok_d;
  logic        err_q, err_d;
  logic        rneg_q, rneg_d;
  logic [16:0] mag_q, mag_d;
  logic [2:0]  pidx_q, pidx_d;
  logic [3:0]  dig_q, dig_d;
  logic        lead_q, lead_d;
  logic        txf_q, txf_d;
  logic [7:0]  txd_q, txd_d;
  logic        updv_q, updv_d;
  sgpc_upd_t   upd_q, upd_d;

  logic        mem_we;
  logic [2:0]  mem_waddr;
  logic [2:0]  mem_raddr;
  logic [15:0] mem_rdata;
  logic        take;
  logic        load;
  logic [7:0]  load_byte;
  logic [7:0]  b;
  logic [20:0] acc;
  logic [16:0] pw;
  logic        is_dig;
  logic        is_mot;
  logic        set_ok;
  logic        emit;
  logic [17:0] sm;
  sgpc_motor_t m;

  sgpc_param_mem i_sgpc_param_mem (
    .i_mclk    (i_mclk),
    .i_sys_rst (i_sys_rst),
    .i_we      (mem_we),
    .i_waddr   (mem_waddr),
    .i_wdata   (val_q[15:0]),
    .i_raddr   (mem_raddr),
    .o_rdata   (mem_rdata)
  );

  // no byte is taken until the reply's closing CR is loaded, so replies stay in order
  assign o_rx_ready = st_q inside {SGPC_IDLE, SGPC_CMD1, SGPC_CMD2,
                                   SGPC_BODY};  // see R17
  assign take       = i_rx_valid & o_rx_ready;
  assign b          = i_rx_data;
  assign is_dig     = (b >= `SGPC_CH_ZERO) && (b <= `SGPC_CH_NINE);
  assign is_mot     = (b >= `SGPC_MOT_FIRST) && (b <= `SGPC_MOT_LAST);
  assign m          = i_motor[mot_q];
  assign pw         = pow10(pidx_q);

  always_comb begin
    st_d      = st_q;
    c1_d      = c1_q;
    c2_d      = c2_q;
    neg_d     = neg_q;
    val_d     = val_q;
    hasdig_d  = hasdig_q;
    bodyn_d   = bodyn_q;
    mot_d     = mot_q;
    motok_d   = motok_q;
    err_d     = err_q;
    rneg_d    = rneg_q;
    mag_d     = mag_q;
    pidx_d    = pidx_q;
    dig_d     = dig_q;
    lead_d    = lead_q;
    updv_d    = 1'b0;
    upd_d     = upd_q;
    mem_we    = 1'b0;
    mem_waddr = {c2_q == `SGPC_K_SPEED, mot_q};
    mem_raddr = {c2_q == `SGPC_K_SPEED, mot_q};
    load      = 1'b0;
    load_byte = `SGPC_CH_CR;
    acc       = ({4'h0, val_q} * `SGPC_TEN) + {17'h0, b[3:0]};
    set_ok    = 1'b0;
    emit      = 1'b0;
    sm        = 18'h0;
    // a '!' anywhere restarts framing; bytes outside a frame are dropped
    if (take && b == `SGPC_CH_BANG) begin
      st_d     = SGPC_CMD1;  // see R1
      neg_d    = 1'b0;
      val_d    = 17'h0;
      hasdig_d = 1'b0;
      bodyn_d  = 4'h0;
      motok_d  = 1'b0;
      err_d    = 1'b0;
    end else begin
      unique case (st_q)
        SGPC_IDLE: begin
        end
        SGPC_CMD1, SGPC_CMD2: begin
          if (take) begin
            if (b == `SGPC_CH_CR) begin
              err_d = 1'b1;  // see R16
              st_d  = SGPC_EXEC;
            end else if (st_q == SGPC_CMD1) begin
              c1_d = b;
              st_d = SGPC_CMD2;
            end else begin
              c2_d = b;
              st_d = SGPC_BODY;
            end
          end
        end
        SGPC_BODY: begin
          if (take) begin
            if (b == `SGPC_CH_CR) begin
              st_d = SGPC_EXEC;  // see R1
            end else begin
              bodyn_d = bodyn_q + 4'h1;
              if (bodyn_q == `SGPC_BODY_MAX) begin
                err_d   = 1'b1;
                bodyn_d = bodyn_q;
              end else if (is_dig && !motok_q) begin
                hasdig_d = 1'b1;  // see R16
                val_d    = (acc > {4'h0, `SGPC_VAL_SAT}) ? `SGPC_VAL_SAT
                                                         : acc[16:0];
              end else if ((b == `SGPC_CH_MINUS || b == `SGPC_CH_PLUS)
                           && bodyn_q == 4'h0) begin
                neg_d = (b == `SGPC_CH_MINUS);  // see R16
              end else if (is_mot && !motok_q) begin
                mot_d   = 2'(b - `SGPC_MOT_FIRST);
                motok_d = 1'b1;
              end else begin
                err_d = 1'b1;  // see R16
              end
            end
          end
        end
        SGPC_EXEC: begin
          rneg_d = 1'b1;
          mag_d  = `SGPC_ACK_BAD;  // see R16
          st_d   = SGPC_HASH;
          if (!err_q && motok_q && c1_q == `SGPC_GRP_SET && hasdig_q
              && !(neg_q && val_q != 17'h0)) begin
            // speed is taken whatever the motion state; the loop rescales
            if (c2_q == `SGPC_K_PGAIN) begin
              set_ok = (val_q <= `SGPC_GAIN_MAX);  // see R2
            end else if (c2_q == `SGPC_K_SPEED) begin
              set_ok = (val_q <= `SGPC_SPEED_MAX);  // see R3, R4
            end
          end
          if (set_ok) begin
            mem_we       = 1'b1;  // see R2, R3
            updv_d       = 1'b1;
            upd_d.kind   = (c2_q == `SGPC_K_SPEED) ? `SGPC_KIND_S
                                                   : `SGPC_KIND_P;
            upd_d.motor  = mot_q;
            upd_d.value  = val_q[15:0];
            rneg_d       = 1'b0;
            mag_d        = `SGPC_ACK_OK;
          end else if (!err_q && motok_q && c1_q == `SGPC_GRP_GET
                       && !hasdig_q && !neg_q) begin
            rneg_d = 1'b0;
            unique case (c2_q)
              `SGPC_K_PGAIN, `SGPC_K_SPEED: st_d = SGPC_READ;  // see R2, R5
              `SGPC_K_FFACC: mag_d = zext16(m.ff_accel);  // see R6
              `SGPC_K_FFDEC: mag_d = zext16(m.ff_decel);  // see R7
              `SGPC_K_AMPL:  mag_d = zext16(m.amplitude);  // see R8
              `SGPC_K_DGAIN: mag_d = zext16(m.deriv_gain);  // see R9
              `SGPC_K_MERR: begin
                mag_d = {9'h0, m.err_word[7:5], 1'b0,
                         m.err_word[3:0]};  // see R10
              end
              `SGPC_K_FRIC:  mag_d = {9'h0, m.ff_friction};  // see R11
              `SGPC_K_IGAIN: mag_d = zext16(m.integ_gain);  // see R12
              `SGPC_K_COFF: begin
                sm     = sgn_mag(m.cur_offset);  // see R13
                rneg_d = sm[17];
                mag_d  = sm[16:0];
              end
              `SGPC_K_POFF: begin
                sm     = sgn_mag(m.prof_offset);  // see R14
                rneg_d = sm[17];
                mag_d  = sm[16:0];
              end
              `SGPC_K_MWARN: begin
                mag_d = {8'h0, m.warn_word[8], 1'b0, m.warn_word[6],
                         2'h0, m.warn_word[3:0]};  // see R15
              end
              default: begin
                rneg_d = 1'b1;
                mag_d  = `SGPC_ACK_BAD;  // see R16
              end
            endcase
          end
        end
        SGPC_READ: begin
          mag_d = zext16(mem_rdata);
          st_d  = SGPC_HASH;
        end
        SGPC_HASH: begin
          if (!txf_q) begin
            load      = 1'b1;
            load_byte = `SGPC_CH_HASH;  // see R1
            pidx_d    = `SGPC_PIDX_TOP;
            dig_d     = 4'h0;
            lead_d    = 1'b0;
            st_d      = rneg_q ? SGPC_SIGN : SGPC_DIG;
          end
        end
        SGPC_SIGN: begin
          if (!txf_q) begin
            load      = 1'b1;
            load_byte = `SGPC_CH_MINUS;
            st_d      = SGPC_DIG;
          end
        end
        SGPC_DIG: begin
          // one subtraction per cycle keeps the divider small
          if (mag_q >= pw) begin
            mag_d = mag_q - pw;
            dig_d = dig_q + 4'h1;
          end else begin
            emit = (dig_q != 4'h0) || lead_q || (pidx_q == 3'h0);
            if (!emit) begin
              pidx_d = pidx_q - 3'h1;
            end else if (!txf_q) begin
              load      = 1'b1;
              load_byte = `SGPC_CH_ZERO | {4'h0, dig_q};
              lead_d    = 1'b1;
              dig_d     = 4'h0;
              if (pidx_q == 3'h0) begin
                st_d = SGPC_TERM;
              end else begin
                pidx_d = pidx_q - 3'h1;
              end
            end
          end
        end
        SGPC_TERM: begin
          if (!txf_q) begin
            load      = 1'b1;
            load_byte = `SGPC_CH_CR;  // see R1, R17
            st_d      = SGPC_IDLE;
          end
        end
      endcase
    end
    txf_d = load | (txf_q & ~i_tx_ready);
    txd_d = load ? load_byte : txd_q;
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_q     <= SGPC_IDLE;
      c1_q     <= 8'h00;
      c2_q     <= 8'h00;
      neg_q    <= 1'b0;
      val_q    <= 17'h0;
      hasdig_q <= 1'b0;
      bodyn_q  <= 4'h0;
      mot_q    <= 2'h0;
      motok_q  <= 1'b0;
      err_q    <= 1'b0;
      rneg_q   <= 1'b0;
      mag_q    <= 17'h0;
      pidx_q   <= 3'h0;
      dig_q    <= 4'h0;
      lead_q   <= 1'b0;
      txf_q    <= 1'b0;
      txd_q    <= 8'h00;
      updv_q   <= 1'b0;
      upd_q    <= '0;
    end else begin
      st_q     <= st_d;
      c1_q     <= c1_d;
      c2_q     <= c2_d;
      neg_q    <= neg_d;
      val_q    <= val_d;
      hasdig_q <= hasdig_d;
      bodyn_q  <= bodyn_d;
      mot_q    <= mot_d;
      motok_q  <= motok_d;
      err_q    <= err_d;
      rneg_q   <= rneg_d;
      mag_q    <= mag_d;
      pidx_q   <= pidx_d;
      dig_q    <= dig_d;
      lead_q   <= lead_d;
      txf_q    <= txf_d;
      txd_q    <= txd_d;
      updv_q   <= updv_d;
      upd_q    <= upd_d;
    end
  end

  assign o_tx_valid  = txf_q;
  assign o_tx_data   = txd_q;
  assign o_upd_valid = updv_q;
  assign o_upd       = upd_q;

endmodule : sgpc_cmd_interp

// ==== rtl/sgpc_param_mem.sv ====
// per-motor store of P gain and profile speed with registered read
`timescale 1ns/10ps
`include "sgpc_regs.svh"
module sgpc_param_mem
  import sgpc_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_we,
  input  wire logic [2:0]  i_waddr,
  input  wire logic [15:0] i_wdata,
  input  wire logic [2:0]  i_raddr,
  output logic      [15:0] o_rdata
);

  logic [15:0] mem_q [8];
  logic [15:0] mem_d [8];
  logic [15:0] rd_q;
  logic [15:0] rd_d;

  always_comb begin
    for (int k = 0; k < 8; k++) begin
      mem_d[k] = mem_q[k];
    end
    if (i_we) begin
      mem_d[i_waddr] = i_wdata;
    end
    rd_d = mem_q[i_raddr];
  end

  // address bit 2 is the kind: speed words start at full designed rate
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      for (int k = 0; k < 8; k++) begin
        mem_q[k] <= (k >= 4) ? `SGPC_SPEED_RST : `SGPC_GAIN_RST;
      end
      rd_q <= `SGPC_GAIN_RST;
    end else begin
      for (int k = 0; k < 8; k++) begin
        mem_q[k] <= mem_d[k];
      end
      rd_q <= rd_d;
    end
  end

  assign o_rdata = rd_q;

endmodule : sgpc_param_mem

// ==== test/sgpc_assertions.sv ====
// concurrent checks on the command interpreter ports
`timescale 1ns/10ps
module sgpc_assertions
  import sgpc_pkg::*;
(
  input wire logic       i_mclk,
  input wire logic       i_sys_rst,
  input wire logic       o_rx_ready,
  input wire logic       o_tx_valid,
  input wire logic [7:0] o_tx_data,
  input wire logic       i_tx_ready,
  input wire logic       o_upd_valid,
  input wire sgpc_upd_t  o_upd
);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_sys_rst);

  a_reply_hash: assert property ($fell(o_rx_ready) |-> ##[1:4]
    (o_tx_valid && o_tx_data == 8'h23))
    else $error("reply does not open with hash");
  a_tx_hold: assert property (o_tx_valid && !i_tx_ready |=>
    o_tx_valid && $stable(o_tx_data))
    else $error("reply byte changed before it was taken");
  a_ready_at_cr: assert property ($rose(o_rx_ready) |->
    o_tx_valid && o_tx_data == 8'h0d)
    else $error("request side reopened before reply end");
  a_busy_hash: assert property (o_tx_valid && o_tx_data == 8'h23
    |-> !o_rx_ready)
    else $error("request taken while reply starts");
  a_upd_pulse: assert property (o_upd_valid |=> !o_upd_valid)
    else $error("update pulse longer than one cycle");
  a_upd_busy: assert property (o_upd_valid |-> !o_rx_ready)
    else $error("update outside reply phase");
  a_gain_range: assert property (o_upd_valid && !o_upd.kind |->
    o_upd.value <= 16'h7f80)
    else $error("gain update out of range");
  a_speed_range: assert property (o_upd_valid && o_upd.kind |->
    o_upd.value <= 16'h1000)
    else $error("speed update out of range");
  a_upd_ack: assert property (o_upd_valid |-> ##[0:3]
    (o_tx_valid && o_tx_data == 8'h23))
    else $error("accepted set not answered");
endmodule : sgpc_assertions

bind sgpc_cmd_interp sgpc_assertions i_sgpc_assertions (
  .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .o_rx_ready(o_rx_ready),
  .o_tx_valid(o_tx_valid), .o_tx_data(o_tx_data), .i_tx_ready(i_tx_ready),
  .o_upd_valid(o_upd_valid), .o_upd(o_upd));

// ==== test/sgpc_host.sv ====
// host side model: sends request frames and collects reply bytes
`timescale 1ns/10ps
module sgpc_host (
  input  wire logic       i_mclk,
  output logic            o_rx_valid,
  output logic [7:0]      o_rx_data,
  input  wire logic       i_rx_ready,
  input  wire logic       i_tx_valid,
  input  wire logic [7:0] i_tx_data,
  output logic            o_tx_ready
);
  logic        slow;
  logic        stuck;
  logic [63:0] rep;
  initial begin
    o_rx_valid = 1'b0;
    o_rx_data  = 8'h00;
    o_tx_ready = 1'b1;
    slow       = 1'b0;
    stuck      = 1'b0;
    rep        = 64'h0;
  end
  // when slow, every other slot is refused to stress the reply holding
  always @(posedge i_mclk) begin
    o_tx_ready <= !slow || !o_tx_ready;
    if (i_tx_valid && o_tx_ready) begin
      rep <= {rep[55:0], i_tx_data};
    end
  end
  // bytes go out first char first; leading zero bytes are padding
  // a byte never taken within the bound raises stuck for the bench
  task automatic send(input logic [79:0] f);
    logic stall;
    @(posedge i_mclk);
    rep <= 64'h0;
    for (int i = 9; i >= 0; i--) begin
      if (f[8*i+:8] != 8'h00) begin
        o_rx_valid <= 1'b1;
        o_rx_data  <= f[8*i+:8];
        stall = 1'b1;
        for (int k = 0; k < 500 && stall; k++) begin
          @(negedge i_mclk);
          stall = !i_rx_ready;
        end
        if (stall) begin
          stuck = 1'b1;
        end
        @(posedge i_mclk);
      end
    end
    o_rx_valid <= 1'b0;
    // released line must not keep looking like a byte
    o_rx_data  <= ~o_rx_data;
  endtask : send
endmodule : sgpc_host

// ==== test/tb_servo_gain_profile_cmds.sv ====
// self-checking bench for the command interpreter
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  failures++; $display("Error %s exp %h got %h", nm, e, g); end end
module tb_servo_gain_profile_cmds
  import sgpc_pkg::*;
;
  logic              i_mclk;
  logic              i_sys_rst;
  logic              rx_valid, rx_ready, tx_valid, tx_ready, upd_valid;
  logic [7:0]        rx_data, tx_data;
  sgpc_motor_t [3:0] motor;
  sgpc_upd_t         upd;
  int                failures = 0;
  int                n_compared = 0;
  int                n_upd = 0;
  logic [63:0]       r;
  logic [7:0]  ks [10] = '{"A", "B", "C", "D", "E", "F", "I", "K", "O", "W"};
  logic [63:0] es [10] = '{"#32640\r", "#1\r", "#4096\r", "#12345\r",
    "#239\r", "#255\r", "#0\r", "#-256\r", "#-32256\r", "#335\r"};
  logic [79:0] bads [6] = '{"!EXA\r", "!EPE\r", "!EP5A\r", "!DPA\r",
    "!DP-5A\r", "!E\r"};

  sgpc_cmd_interp i_sgpc_cmd_interp (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
    .i_rx_valid(rx_valid), .i_rx_data(rx_data), .o_rx_ready(rx_ready),
    .o_tx_valid(tx_valid), .o_tx_data(tx_data), .i_tx_ready(tx_ready),
    .i_motor(motor), .o_upd_valid(upd_valid), .o_upd(upd));
  sgpc_host i_sgpc_host (.i_mclk(i_mclk), .o_rx_valid(rx_valid),
    .o_rx_data(rx_data), .i_rx_ready(rx_ready), .i_tx_valid(tx_valid),
    .i_tx_data(tx_data), .o_tx_ready(tx_ready));

  initial begin
    i_mclk = 1'b0;
    forever #20 i_mclk = ~i_mclk;
  end
  always @(posedge i_mclk) if (upd_valid === 1'b1) n_upd++;

  task automatic close_out;
    if (failures == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out

  // the quiet tail after the reply shows up any second reply
  task automatic run(input logic [79:0] f);
    i_sgpc_host.send(f);
    for (int k = 0; k < 3000 && i_sgpc_host.rep[7:0] !== 8'h0d; k++)
      @(posedge i_mclk);
    if (i_sgpc_host.rep[7:0] !== 8'h0d || i_sgpc_host.stuck !== 1'b0) begin
      failures++;
      close_out();
    end
    repeat (20) @(posedge i_mclk);
    r = i_sgpc_host.rep;
  endtask : run

  task automatic t_gain;
    int n;
    n = n_upd;
    run("!DP32640A\r");
    `CHK("set p ack", "#0\r", r)
    `CHK("p update", {1'b0, 2'h0, 16'h7f80}, upd)
    run("!EPA\r");
    `CHK("get p", "#32640\r", r)
    run("!DP32641B\r");
    `CHK("p over", "#-1\r", r)
    run("!EPB\r");
    `CHK("p kept", "#0\r", r)
    `CHK("p pulses", n + 1, n_upd)
  endtask : t_gain

  task automatic t_speed;
    i_sgpc_host.slow <= 1'b1;
    run("!ESC\r");
    `CHK("speed reset", "#4096\r", r)
    run("!DS4097C\r");
    `CHK("speed over", "#-1\r", r)
    run("!DS4096D\r");
    `CHK("speed max", "#0\r", r)
    run("!DS0C\r");
    `CHK("speed update", {1'b1, 2'h2, 16'h0000}, upd)
    run("!ESC\r");
    `CHK("get speed", "#0\r", r)
    i_sgpc_host.slow <= 1'b0;
  endtask : t_speed

  task automatic t_gets;
    @(posedge i_mclk);
    motor[3] <= '{16'h7f80, 16'h0001, 16'h1000, 16'h3039, 16'h0000,
                 8'hff, 16'hff00, 16'h8200, 8'hff, 9'h1ff};
    for (int i = 0; i < 10; i++) begin
      run({"!E", ks[i], "D\r"});
      `CHK("get item", es[i], r)
    end
  endtask : t_gets

  task automatic t_bad;
    int n;
    n = n_upd;
    for (int i = 0; i < 6; i++) begin
      run(bads[i]);
      `CHK("refused", "#-1\r", r)
    end
    run("!DP7!DP9B\r");
    `CHK("restart ack", "#0\r", r)
    run("!EPB\r");
    `CHK("restart value", "#9\r", r)
    run("!DP+12C\r");
    `CHK("plus ack", "#0\r", r)
    `CHK("plus update", {1'b0, 2'h2, 16'h000c}, upd)
    `CHK("bad pulses", n + 2, n_upd)
  endtask : t_bad

  // a second reset mid run must bring back the stored defaults
  task automatic t_reset;
    @(posedge i_mclk);
    i_sys_rst <= 1'b1;
    repeat (2) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    `CHK("upd reset", 19'h00000, upd)
    run("!EPB\r");
    `CHK("p after reset", "#0\r", r)
    run("!ESC\r");
    `CHK("speed after reset", "#4096\r", r)
  endtask : t_reset

  initial begin
    i_sys_rst = 1'b1;
    motor     = '0;
    repeat (2) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    t_gain();
    t_speed();
    t_gets();
    t_bad();
    t_reset();
    close_out();
  end
endmodule : tb_servo_gain_profile_cmds
